// >>> asq_pkg.sv
// Purpose: Shared constants and types for the converter slot sequencer and status block.
// Assumes: 8-bit register port in the processor's data and special-register spaces.
// Notes: Register offsets, field positions, the selector reset values and the debounce timing live here.

package asq_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] ASQ_MISC_STATUS_OFS = 16'h00f8;
  localparam logic [15:0] ASQ_LINK_ERR_OFS = 16'h00fc;
  localparam logic [15:0] ASQ_SLOT10_LEN_OFS = 16'h2100;
  localparam logic [15:0] ASQ_SLOT8_9_OFS = 16'h2101;
  localparam logic [15:0] ASQ_SLOT6_7_OFS = 16'h2102;
  localparam logic [15:0] ASQ_SLOT4_5_OFS = 16'h2103;
  localparam logic [15:0] ASQ_SLOT2_3_OFS = 16'h2104;

  // Field positions.
  localparam int ASQ_BTN_LEVEL_BIT = 0;
  localparam int ASQ_RD_PERR_BIT = 6;
  localparam int ASQ_WR_PERR_BIT = 5;
  localparam int ASQ_LOW_NIB_LSB = 0;
  localparam int ASQ_HIGH_NIB_LSB = 4;

  // Reset values.
  localparam logic [7:0] ASQ_SEL_RESET = 8'h00;
  localparam logic [3:0] ASQ_NIB_RESET = 4'h0;

  // Frame geometry.
  localparam int ASQ_SLOT_CNT = 11;
  localparam logic [3:0] ASQ_MAX_FRAME_LEN = 4'hb;
  localparam logic [3:0] ASQ_FIRST_SEL_SLOT = 4'h2;

  // Timing.
  localparam int ASQ_CLK_PERIOD_PS = 5000;
  localparam int ASQ_BTN_DEBOUNCE_NS = 10000;
  localparam int ASQ_BTN_DEBOUNCE_CYC =
    (ASQ_BTN_DEBOUNCE_NS * 1000 + ASQ_CLK_PERIOD_PS - 1) / ASQ_CLK_PERIOD_PS;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic sfr_space;
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } asq_reg_req_t;

  typedef struct packed {
    logic frame_start;
    logic [3:0] slot_index;
    logic select_valid;
    logic [3:0] input_select;
  } asq_slot_out_t;

endpackage : asq_pkg

// >>> asq_sensor_model.sv
// Purpose: Far-side model of the converter slot timer and the remote sensor link.
// Assumes: Same clock as the block under test.
// Notes: Ticks every cycle or every fourth; parity faults only on command.
`timescale 1ns/1ps
module asq_sensor_model
  import asq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic slow,
  input wire logic [1:0] err_cmd,
  output logic slot_tick,
  output logic rd_err,
  output logic wr_err
);
  logic [1:0] cnt_reg;
  // Slot timer restarts whenever run drops, so no stray tick follows a stop.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= 2'h0;
      slot_tick <= 1'b0;
      rd_err <= 1'b0;
      wr_err <= 1'b0;
    end else begin
      cnt_reg <= run ? cnt_reg + 2'h1 : 2'h0;
      slot_tick <= run && (!slow || cnt_reg == 2'h3);
      rd_err <= err_cmd[1];
      wr_err <= err_cmd[0];
    end
  end
endmodule : asq_sensor_model

// >>> asq_slot_sequencer.sv
// Purpose: Slot selector registers, frame sequencer, pushbutton status and link parity flags.
// Assumes: Single clock clk_sys at 200 MHz, asynchronous active-high reset rst.
// Notes: Parity error pulses and slot ticks come from logic on the same clock.
//
// Behaviour
// - Slots two to ten convert their selector.
// - Slots two and three use one shared byte.
// - Frame length from upper nibble at slot10.
// - Debounced pushbutton readable, zero after reset.
// - Parity errors on sensor link set flags.
// - Flags hold until processor clears by writing.

`timescale 1ns/1ps

module asq_slot_sequencer
  import asq_pkg::*;
#(
  parameter int DEBOUNCE_CYC = ASQ_BTN_DEBOUNCE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire asq_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic slot_tick,
  output asq_slot_out_t slot_out,
  input wire logic pushbutton_input,
  input wire logic sensor_read_parity_error,
  input wire logic sensor_write_parity_error
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC > 65535) begin : g_bad_debounce
    $error("DEBOUNCE_CYC must lie between 1 and 65535.");
  end

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------

  // Returns one when the request addresses the given location in the given space.
  function automatic logic hit(input asq_reg_req_t r, input logic sfr, input logic [15:0] ofs);
    hit = (r.sfr_space == sfr) && (r.addr == ofs);
  endfunction : hit

  logic wr_slot10_len;
  logic wr_slot8_9;
  logic wr_slot6_7;
  logic wr_slot4_5;
  logic wr_slot2_3;
  logic wr_link_err;

  // Write strobes for each writable location.
  assign wr_slot10_len = reg_req.wr && hit(reg_req, 1'b0, ASQ_SLOT10_LEN_OFS);
  assign wr_slot8_9 = reg_req.wr && hit(reg_req, 1'b0, ASQ_SLOT8_9_OFS);
  assign wr_slot6_7 = reg_req.wr && hit(reg_req, 1'b0, ASQ_SLOT6_7_OFS);
  assign wr_slot4_5 = reg_req.wr && hit(reg_req, 1'b0, ASQ_SLOT4_5_OFS);
  assign wr_slot2_3 = reg_req.wr && hit(reg_req, 1'b0, ASQ_SLOT2_3_OFS);
  assign wr_link_err = reg_req.wr && hit(reg_req, 1'b1, ASQ_LINK_ERR_OFS);

  // ---------------------------------------------------------------------------
  // Slot selector and frame length registers
  // ---------------------------------------------------------------------------
  logic [7:0] slot10_len_reg;
  logic [7:0] slot8_9_reg;
  logic [7:0] slot6_7_reg;
  logic [7:0] slot4_5_reg;
  logic [7:0] slot2_3_reg;

  // Each selector byte takes a full write; all fields start at zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot10_len_reg <= ASQ_SEL_RESET;
      slot8_9_reg <= ASQ_SEL_RESET;
      slot6_7_reg <= ASQ_SEL_RESET;
      slot4_5_reg <= ASQ_SEL_RESET;
      slot2_3_reg <= ASQ_SEL_RESET;
    end else begin
      if (wr_slot10_len) begin
        slot10_len_reg <= reg_req.wdata;
      end
      if (wr_slot8_9) begin
        slot8_9_reg <= reg_req.wdata;
      end
      if (wr_slot6_7) begin
        slot6_7_reg <= reg_req.wdata;
      end
      if (wr_slot4_5) begin
        slot4_5_reg <= reg_req.wdata;
      end
      if (wr_slot2_3) begin
        slot2_3_reg <= reg_req.wdata;
      end
    end
  end

  // Per-slot selector table, index equals slot number; slots 0 and 1 carry none.
  logic [3:0] slot_sel [ASQ_SLOT_CNT];
  logic [3:0] frame_len_raw;
  logic [3:0] frame_len;

  assign slot_sel[0] = ASQ_NIB_RESET;
  assign slot_sel[1] = ASQ_NIB_RESET;
  assign slot_sel[2] = slot2_3_reg[ASQ_LOW_NIB_LSB +: 4];
  assign slot_sel[3] = slot2_3_reg[ASQ_HIGH_NIB_LSB +: 4];
  assign slot_sel[4] = slot4_5_reg[ASQ_LOW_NIB_LSB +: 4];
  assign slot_sel[5] = slot4_5_reg[ASQ_HIGH_NIB_LSB +: 4];
  assign slot_sel[6] = slot6_7_reg[ASQ_LOW_NIB_LSB +: 4];
  assign slot_sel[7] = slot6_7_reg[ASQ_HIGH_NIB_LSB +: 4];
  assign slot_sel[8] = slot8_9_reg[ASQ_LOW_NIB_LSB +: 4];
  assign slot_sel[9] = slot8_9_reg[ASQ_HIGH_NIB_LSB +: 4];
  assign slot_sel[10] = slot10_len_reg[ASQ_LOW_NIB_LSB +: 4];

  // Frame length; an unsupported value above eleven is held at eleven so the
  // sequencer never walks off the selector table.
  assign frame_len_raw = slot10_len_reg[ASQ_HIGH_NIB_LSB +: 4];
  assign frame_len = (frame_len_raw > ASQ_MAX_FRAME_LEN) ? ASQ_MAX_FRAME_LEN
                                                          : frame_len_raw;

  // ---------------------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ASQ_IDLE = 2'b01,
    ASQ_RUN = 2'b10
  } asq_seq_state_t;

  asq_seq_state_t seq_state_reg;
  logic [3:0] slot_cnt_reg;
  logic [3:0] slot_cnt_next;
  logic wrap;

  // The last slot of the frame is length minus one; a shortened length while
  // running also ends the frame at once.
  assign wrap = (slot_cnt_reg >= frame_len - 4'h1);

  assign slot_cnt_next = wrap ? 4'h0 : slot_cnt_reg + 4'h1;

  // Walks slots on each tick; a zero frame length holds the sequencer idle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seq_state_reg <= ASQ_IDLE;
      slot_cnt_reg <= 4'h0;
    end else begin
      case (seq_state_reg)
        ASQ_IDLE: begin
          // The tick that leaves idle is slot zero, so the count moves past it.
          if (slot_tick && frame_len != 4'h0) begin
            seq_state_reg <= ASQ_RUN;
            slot_cnt_reg <= slot_cnt_next;
          end
        end
        ASQ_RUN: begin
          if (frame_len == 4'h0) begin
            seq_state_reg <= ASQ_IDLE;
            slot_cnt_reg <= 4'h0;
          end else if (slot_tick) begin
            slot_cnt_reg <= slot_cnt_next;
          end
        end
        default: begin
          seq_state_reg <= ASQ_IDLE;
          slot_cnt_reg <= 4'h0;
        end
      endcase
    end
  end

  logic slot_active;
  logic in_frame;

  // A slot is converted while running inside the programmed length, or on the tick that leaves idle.
  assign in_frame = (slot_cnt_reg < frame_len);
  assign slot_active = slot_tick && (((seq_state_reg == ASQ_RUN) && in_frame) ||
                       ((seq_state_reg == ASQ_IDLE) && (frame_len != 4'h0)));

  logic [3:0] cur_slot;

  // The idle state starts its first frame at slot zero.
  assign cur_slot = (seq_state_reg == ASQ_RUN) ? slot_cnt_reg : 4'h0;

  // Registered converter command for the slot announced by each tick.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot_out <= '0;
    end else begin
      slot_out.frame_start <= slot_active && (cur_slot == 4'h0);
      if (slot_active) begin
        slot_out.slot_index <= cur_slot;
        slot_out.select_valid <= (cur_slot >= ASQ_FIRST_SEL_SLOT);
        slot_out.input_select <= slot_sel[cur_slot];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pushbutton debounce
  // ---------------------------------------------------------------------------
  logic btn_meta_reg;
  logic btn_sync_reg;
  logic pushbutton_level_reg;
  logic [15:0] btn_cnt_reg;

  // Two-stage synchroniser for the pushbutton pin.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      btn_meta_reg <= 1'b0;
      btn_sync_reg <= 1'b0;
    end else begin
      btn_meta_reg <= pushbutton_input;
      btn_sync_reg <= btn_meta_reg;
    end
  end

  // The level changes only after the input has differed for the full window.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pushbutton_level_reg <= 1'b0;
      btn_cnt_reg <= 16'h0000;
    end else if (btn_sync_reg == pushbutton_level_reg) begin
      btn_cnt_reg <= 16'h0000;
    end else if (btn_cnt_reg >= 16'(DEBOUNCE_CYC - 1)) begin
      pushbutton_level_reg <= btn_sync_reg;
      btn_cnt_reg <= 16'h0000;
    end else begin
      btn_cnt_reg <= btn_cnt_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Sensor link parity flags
  // ---------------------------------------------------------------------------
  logic rd_perr_reg;
  logic wr_perr_reg;

  // Sticky flags; writing zero clears, and a new error in that cycle wins.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_perr_reg <= 1'b0;
      wr_perr_reg <= 1'b0;
    end else begin
      if (sensor_read_parity_error) begin
        rd_perr_reg <= 1'b1;
      end else if (wr_link_err && !reg_req.wdata[ASQ_RD_PERR_BIT]) begin
        rd_perr_reg <= 1'b0;
      end
      if (sensor_write_parity_error) begin
        wr_perr_reg <= 1'b1;
      end else if (wr_link_err && !reg_req.wdata[ASQ_WR_PERR_BIT]) begin
        wr_perr_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [7:0] rd_mux;

  // Unmapped locations and reserved bits read as zero.
  always_comb begin
    rd_mux = 8'h00;
    if (hit(reg_req, 1'b0, ASQ_SLOT10_LEN_OFS)) begin
      rd_mux = slot10_len_reg;
    end else if (hit(reg_req, 1'b0, ASQ_SLOT8_9_OFS)) begin
      rd_mux = slot8_9_reg;
    end else if (hit(reg_req, 1'b0, ASQ_SLOT6_7_OFS)) begin
      rd_mux = slot6_7_reg;
    end else if (hit(reg_req, 1'b0, ASQ_SLOT4_5_OFS)) begin
      rd_mux = slot4_5_reg;
    end else if (hit(reg_req, 1'b0, ASQ_SLOT2_3_OFS)) begin
      rd_mux = slot2_3_reg;
    end else if (hit(reg_req, 1'b1, ASQ_MISC_STATUS_OFS)) begin
      rd_mux[ASQ_BTN_LEVEL_BIT] = pushbutton_level_reg;
    end else if (hit(reg_req, 1'b1, ASQ_LINK_ERR_OFS)) begin
      rd_mux[ASQ_RD_PERR_BIT] = rd_perr_reg;
      rd_mux[ASQ_WR_PERR_BIT] = wr_perr_reg;
    end
  end

  // Read data is registered and valid for one cycle after the strobe.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule : asq_slot_sequencer

// >>> asq_slot_sequencer_assertions.sv
// Purpose: Port checker for the slot sequencer.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Mirrors selector bytes from the writes seen at the port.
`timescale 1ns/1ps
module asq_slot_sequencer_assertions
  import asq_pkg::*;
#(
  parameter int DEBOUNCE_CYC = ASQ_BTN_DEBOUNCE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire asq_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic slot_tick,
  input wire asq_slot_out_t slot_out
);
  logic [7:0] sh_reg [0:4];
  logic [7:0] sel_w;
  logic [3:0] len_w;
  logic [3:0] want_w;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // -------------------------------------------------------------------------
  // Shadow of the selector bytes
  // -------------------------------------------------------------------------
  // Keeps a copy of each selector byte as the processor writes it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) begin
        sh_reg[i] <= 8'h00;
      end
    end else if (reg_req.wr && !reg_req.sfr_space && reg_req.addr >= 16'h2100
                 && reg_req.addr <= 16'h2104) begin
      sh_reg[reg_req.addr[2:0]] <= reg_req.wdata;
    end
  end
  // Frame length clamps at eleven; the selector nibble follows slot parity.
  assign len_w = (sh_reg[0][7:4] > 4'hb) ? 4'hb : sh_reg[0][7:4];
  assign sel_w = sh_reg[3'h5 - slot_out.slot_index[3:1]];
  assign want_w = slot_out.slot_index[0] ? sel_w[7:4] : sel_w[3:0];
  sequence s_tick;
    slot_tick && len_w != 4'h0 && !reg_req.wr;
  endsequence
  property p_read_answer;
    reg_req.rd |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_spurious;
    !reg_req.rd |=> !reg_rvalid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("stray read valid");
  property p_rdata_hold;
    !reg_rvalid |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_advance;
    s_tick |=> slot_out.frame_start || slot_out.slot_index == $past(slot_out.slot_index) + 4'h1;
  endproperty
  a_advance: assert property (p_advance) else $error("slot did not advance");
  property p_wrap;
    s_tick |=> slot_out.slot_index < len_w;
  endproperty
  a_wrap: assert property (p_wrap) else $error("slot beyond frame");
  property p_start_zero;
    slot_out.frame_start |-> slot_out.slot_index == 4'h0 && !slot_out.select_valid;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("frame start not slot 0");
  property p_select;
    s_tick |=> !slot_out.select_valid || slot_out.input_select == want_w;
  endproperty
  a_select: assert property (p_select) else $error("wrong input selected");
  property p_valid_range;
    slot_out.select_valid == (slot_out.slot_index >= 4'h2)
      && (slot_out.select_valid || slot_out.input_select == 4'h0);
  endproperty
  a_valid_range: assert property (p_valid_range) else $error("select valid wrong");
  property p_idle;
    slot_tick && len_w == 4'h0 && !slot_out.frame_start |=> $stable(slot_out);
  endproperty
  a_idle: assert property (p_idle) else $error("idle frame moved");
endmodule : asq_slot_sequencer_assertions
bind asq_slot_sequencer asq_slot_sequencer_assertions #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) chk_u (
  .clk_sys, .rst, .reg_req, .reg_rdata, .reg_rvalid, .slot_tick, .slot_out);

// >>> asq_slot_sequencer_tb.sv
// Purpose: Self-checking bench for the slot sequencer.
// Assumes: The sensor model makes slot ticks and parity faults.
// Notes: Debounce shortened to 4 cycles; selector for slot s is s.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module asq_slot_sequencer_tb
  import asq_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  asq_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic slot_tick;
  logic rd_err;
  logic wr_err;
  asq_slot_out_t slot_out;
  logic btn = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b1;
  logic [1:0] err_cmd = 2'b00;
  logic [7:0] bytes [0:4] = '{8'hba, 8'h98, 8'h76, 8'h54, 8'h32};
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  asq_slot_sequencer #(.DEBOUNCE_CYC(4)) dut_u (.clk_sys, .rst, .reg_req, .reg_rdata,
    .reg_rvalid, .slot_tick, .slot_out, .pushbutton_input(btn),
    .sensor_read_parity_error(rd_err), .sensor_write_parity_error(wr_err));
  asq_sensor_model model_u (.clk_sys, .rst, .run, .slow, .err_cmd, .slot_tick, .rd_err,
    .wr_err);
  // Cuts a hang short well past the expected run length.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  // -------------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{a < 16'h0100, a, 1'b1, 1'b0, d};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= '{a < 16'h0100, a, 1'b0, 1'b1, 8'h00};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rd
  // Runs slow ticks and checks slot, frame start and selected input.
  task automatic frame(input int len, input int n);
    @(posedge clk_sys);
    run <= 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_sys iff slot_tick);
      #1;
      `CHK(slot_out.slot_index, 4'(k % len))
      `CHK(slot_out.frame_start, k % len == 0)
      `CHK(slot_out.select_valid, k % len >= 2)
      `CHK(slot_out.input_select, (k % len < 2) ? 4'h0 : 4'(k % len))
    end
    @(posedge clk_sys);
    run <= 1'b0;
  endtask : frame
  task automatic parity();
    @(posedge clk_sys);
    err_cmd <= 2'b10;
    @(posedge clk_sys);
    err_cmd <= 2'b01;
    @(posedge clk_sys);
    err_cmd <= 2'b00;
    rd(16'h00fc, 8'h60);
    rd(16'h00fc, 8'h60);
    wr(16'h00fc, 8'hbf);
    rd(16'h00fc, 8'h20);
    wr(16'h00fc, 8'h00);
    rd(16'h00fc, 8'h00);
    // An error pulse in the same cycle as a clearing write must leave the flags set.
    @(posedge clk_sys);
    err_cmd <= 2'b11;
    @(posedge clk_sys);
    err_cmd <= 2'b00;
    reg_req <= '{1'b1, 16'h00fc, 1'b1, 1'b0, 8'h00};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
    rd(16'h00fc, 8'h60);
  endtask : parity
  // Drives the pin to a level, waits, then reads the debounced status bit.
  task automatic button(input logic lvl, input int hold, input logic [7:0] e);
    @(posedge clk_sys);
    btn <= lvl;
    repeat (hold) @(posedge clk_sys);
    rd(16'h00f8, e);
  endtask : button
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // Main sequence: reset values, selectors, frames, idle, parity, pushbutton.
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(16'h00f8, 8'h00);
    rd(16'h00fc, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rd(16'h2100 + 16'(i), 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      wr(16'h2100 + 16'(i), bytes[i]);
      rd(16'h2100 + 16'(i), bytes[i]);
    end
    frame(11, 22);
    wr(16'h2100, 8'h3a);
    frame(3, 6);
    wr(16'h2100, 8'h0a);
    @(posedge clk_sys);
    slow <= 1'b0;
    run <= 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    `CHK(slot_out.slot_index, 4'h2)
    wr(16'h2100, 8'hba);
    repeat (30) @(posedge clk_sys);
    run <= 1'b0;
    #1;
    `CHK(slot_out.slot_index, 4'h7)
    `CHK(slot_out.input_select, 4'h7)
    parity();
    button(1'b1, 4, 8'h00);
    button(1'b1, 0, 8'h01);
    wr(16'h00f8, 8'h00);
    rd(16'h00f8, 8'h01);
    button(1'b0, 0, 8'h01);
    button(1'b1, 0, 8'h01);
    button(1'b0, 8, 8'h00);
    results();
  end
endmodule : asq_slot_sequencer_tb
